/* File: design/timer_capture_pwm.sv */
`timescale 1ns/100ps
module timer_capture_pwm (
  input  wire logic                               sys_clk_in,
  input  wire logic                               reset_in,
  input  wire logic                               ce_in,
  input  wire logic                               psel_in,
  input  wire logic                               penable_in,
  input  wire logic                               pwrite_in,
  input  wire logic [timer_capture_pkg::AW-1:0]   paddr_in,
  input  wire logic [timer_capture_pkg::DW-1:0]   pwdata_in,
  output logic      [timer_capture_pkg::DW-1:0]   prdata_out,
  output logic                                    pready_out,
  output logic                                    pslverr_out,
  input  wire logic [timer_capture_pkg::NUM_TIMERS-1:0] capture_pin_in,
  output logic      [timer_capture_pkg::NUM_TIMERS-1:0] pwm_out,
  output logic      [timer_capture_pkg::NUM_TIMERS-1:0] adc_trig_out,
  output logic      [timer_capture_pkg::NUM_TIMERS-1:0] dma_req_out
);
  import timer_capture_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [2:0]            cfg_q;
  mode_t                 mode_q   [NUM_TIMERS];
  ctl_t                  ctl_q    [NUM_TIMERS];
  logic [HW-1:0]         ilr_q    [NUM_TIMERS];
  logic [HW-1:0]         match_q  [NUM_TIMERS];
  logic [PW-1:0]         pre_q    [NUM_TIMERS];
  logic [PW-1:0]         pmatch_q [NUM_TIMERS];
  logic [CW-1:0]         cnt_q    [NUM_TIMERS];
  logic [HW-1:0]         free_q   [NUM_TIMERS];
  logic [HW-1:0]         cap_q    [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] imr_cm_q, imr_ce_q, cm_raw_q, ce_raw_q;
  logic [NUM_TIMERS-1:0] sync1_q, sync2_q, prev_q, en_prev_q, lvl_q;
  logic [NUM_TIMERS-1:0] pwm_q, adc_q, dma_q;
  logic                  ack_q;
  logic [DW-1:0]         prdata_q;

  // ****************************************
  // decode
  // ****************************************
  logic [NUM_TIMERS-1:0] ecnt_on, etime_on, pwm_on, evt, hit, ce_set, en_rise, ecnt_ev, cm_clr, ce_clr;
  logic [HW-1:0]         tread [NUM_TIMERS];
  logic                  access, wr_acc, cat32, mapped;
  logic [DW-1:0]         rdata;

  // one wait state: read data is latched in the first access cycle
  assign access      = psel_in & penable_in;
  assign pready_out  = access & ack_q & ce_in;
  assign wr_acc      = pready_out & pwrite_in;
  assign cat32       = (cfg_q == CFG_CAT32) | (cfg_q == CFG_CAT_RTC); // R19
  assign prdata_out  = prdata_q;
  assign pslverr_out = pready_out & ~mapped;
  assign pwm_out     = pwm_q;
  assign adc_trig_out = adc_q;
  assign dma_req_out  = dma_q;

  // per-timer mode decode, edge qualification and match detection
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ecnt_on[i]  = (mode_q[i].mr == MR_CAPTURE) & ~mode_q[i].cmr & ~mode_q[i].ams;  // R3
      etime_on[i] = (mode_q[i].mr == MR_CAPTURE) & mode_q[i].cmr;                     // R10
      pwm_on[i]   = mode_q[i].ams & ~mode_q[i].cmr
                  & ((mode_q[i].mr == MR_ONESHOT) | (mode_q[i].mr == MR_PERIODIC));   // R14
      unique case (ctl_q[i].evt)
        EVT_RISE: evt[i] = sync2_q[i] & ~prev_q[i];                                    // R22
        EVT_FALL: evt[i] = ~sync2_q[i] & prev_q[i];
        EVT_BOTH: evt[i] = sync2_q[i] ^ prev_q[i];
        default:  evt[i] = 1'b0;
      endcase
      en_rise[i] = ctl_q[i].en & ~en_prev_q[i];
      // a match is taken from the decremented value so load-minus-match edges are counted
      ecnt_ev[i] = ecnt_on[i] & ctl_q[i].en & ~en_rise[i] & evt[i];
      hit[i]     = ecnt_ev[i] & ((cnt_q[i] - ONE_CNT) == {pmatch_q[i], match_q[i]});  // R5
      ce_set[i]  = etime_on[i] & ctl_q[i].en & ~en_rise[i] & evt[i];                  // R11
      tread[i]   = etime_on[i] ? cap_q[i] : (ecnt_on[i] ? cnt_q[i][HW-1:0] : free_q[i]); // R7 R13 R17
      cm_clr[i]  = wr_acc & (paddr_in == OFF_ICR) & pwdata_in[i*LANE + RIS_CM_BIT];
      ce_clr[i]  = wr_acc & (paddr_in == OFF_ICR) & pwdata_in[i*LANE + RIS_CE_BIT];
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rdata  = '0;
    mapped = 1'b1;
    unique case (paddr_in)
      OFF_CFG:                   rdata = {29'h0, cfg_q};
      OFF_MODE:                  rdata = {28'h0, mode_q[0]};
      OFF_MODE + TIMER_STRIDE:   rdata = {28'h0, mode_q[1]};
      OFF_CTL:                   rdata = {16'h0, ctl_q[1] & CTL_RW_MASK, ctl_q[0] & CTL_RW_MASK};
      OFF_IMR:                   rdata = {21'h0, imr_ce_q[1], imr_cm_q[1], 6'h0, imr_ce_q[0], imr_cm_q[0], 1'b0};
      OFF_RIS:                   rdata = {21'h0, ce_raw_q[1], cm_raw_q[1], 6'h0, ce_raw_q[0], cm_raw_q[0], 1'b0};
      OFF_MIS:                   rdata = {21'h0, ce_raw_q[1] & imr_ce_q[1], cm_raw_q[1] & imr_cm_q[1], 6'h0,
                                          ce_raw_q[0] & imr_ce_q[0], cm_raw_q[0] & imr_cm_q[0], 1'b0}; // R6
      OFF_ILR:                   rdata = {cat32 ? ilr_q[1] : ZERO_HALF, ilr_q[0]};
      OFF_ILR + TIMER_STRIDE:    rdata = {ZERO_HALF, ilr_q[1]};
      OFF_MATCH:                 rdata = {cat32 ? match_q[1] : ZERO_HALF, match_q[0]};
      OFF_MATCH + TIMER_STRIDE:  rdata = {ZERO_HALF, match_q[1]};
      OFF_PRE:                   rdata = {24'h0, pre_q[0]};
      OFF_PRE + TIMER_STRIDE:    rdata = {24'h0, pre_q[1]};
      OFF_PMATCH:                rdata = {24'h0, pmatch_q[0]};
      OFF_PMATCH + TIMER_STRIDE: rdata = {24'h0, pmatch_q[1]};
      OFF_COUNT:                 rdata = {cat32 ? tread[1] : ZERO_HALF, tread[0]};   // R21
      OFF_COUNT + TIMER_STRIDE:  rdata = {ZERO_HALF, tread[1]};
      OFF_VALUE:                 rdata = {cat32 ? free_q[1] : ZERO_HALF, free_q[0]}; // R21
      OFF_VALUE + TIMER_STRIDE:  rdata = {ZERO_HALF, free_q[1]};
      OFF_ICR:                   rdata = '0;
      default:                   mapped = 1'b0;
    endcase
  end

  // ****************************************
  // apb handshake
  // ****************************************
  // ack toggles so back-to-back transfers each get their own wait state
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q    <= 1'b0;
      prdata_q <= '0;
    end else if (ce_in) begin
      ack_q <= access & ~ack_q;
      if (access & ~ack_q & ~pwrite_in) begin
        prdata_q <= rdata;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // software-owned fields; the enable bit is handled with the control register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_q    <= RST_CFG;
      imr_cm_q <= '0;
      imr_ce_q <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        mode_q[i]   <= MODE_RST;
        ilr_q[i]    <= RST_HALF;
        match_q[i]  <= RST_HALF;
        pre_q[i]    <= RST_BYTE;
        pmatch_q[i] <= RST_BYTE;
      end
    end else if (ce_in && wr_acc) begin
      if (paddr_in == OFF_CFG) begin
        cfg_q <= pwdata_in[2:0];
      end
      if (paddr_in == OFF_IMR) begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
          imr_cm_q[i] <= pwdata_in[i*LANE + RIS_CM_BIT];
          imr_ce_q[i] <= pwdata_in[i*LANE + RIS_CE_BIT];
        end
      end
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (paddr_in == OFF_MODE + AW'(i) * TIMER_STRIDE) begin
          mode_q[i] <= pwdata_in[3:0];
        end
        if (paddr_in == OFF_ILR + AW'(i) * TIMER_STRIDE) begin
          ilr_q[i] <= pwdata_in[HW-1:0];
        end
        if (paddr_in == OFF_MATCH + AW'(i) * TIMER_STRIDE) begin
          match_q[i] <= pwdata_in[HW-1:0];
        end
        if (paddr_in == OFF_PRE + AW'(i) * TIMER_STRIDE) begin
          pre_q[i] <= pwdata_in[PW-1:0];
        end
        if (paddr_in == OFF_PMATCH + AW'(i) * TIMER_STRIDE) begin
          pmatch_q[i] <= pwdata_in[PW-1:0];
        end
      end
      // 32-bit write to the a word also fills b from the upper half
      if (cat32 && paddr_in == OFF_ILR) begin
        ilr_q[1] <= pwdata_in[DW-1:HW]; // R20
      end
      if (cat32 && paddr_in == OFF_MATCH) begin
        match_q[1] <= pwdata_in[DW-1:HW]; // R19
      end
    end
  end

  // control register; a match in the same cycle as a write still drops the enable
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctl_q[i] <= CTL_RST;
      end
    end else if (ce_in) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (hit[i]) begin
          ctl_q[i].en <= 1'b0; // R9
        end else if (wr_acc && paddr_in == OFF_CTL) begin
          ctl_q[i] <= pwdata_in[i*LANE +: LANE] & CTL_RW_MASK;
        end
      end
    end
  end

  // ****************************************
  // pin synchroniser and edge history
  // ****************************************
  // sync1 feeds only sync2; edges are taken between sync2 and its previous value
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else if (ce_in) begin
      sync1_q <= capture_pin_in; // R22
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ****************************************
  // counters
  // ****************************************
  // free counter serves edge-time, pwm and the value view of edge-count
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      en_prev_q <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        cnt_q[i]  <= '0;
        free_q[i] <= RST_HALF;
        cap_q[i]  <= RST_HALF;
      end
    end else if (ce_in) begin
      en_prev_q <= {ctl_q[1].en, ctl_q[0].en};
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (en_rise[i]) begin
          cnt_q[i]  <= {pre_q[i], ilr_q[i]}; // R2 R4
          free_q[i] <= ilr_q[i];              // R4
          cap_q[i]  <= ilr_q[i];
        end else if (ctl_q[i].en) begin
          // timeout reloads one cycle after zero is shown
          free_q[i] <= (free_q[i] == ZERO_HALF) ? ilr_q[i] : free_q[i] - ONE_HALF; // R12 R15
          if (ecnt_ev[i]) begin
            cnt_q[i] <= hit[i] ? {pre_q[i], ilr_q[i]} : cnt_q[i] - ONE_CNT; // R5 R9
          end
          if (ce_set[i]) begin
            cap_q[i] <= free_q[i]; // R11 R13
          end
        end
      end
    end
  end

  // ****************************************
  // pwm output
  // ****************************************
  // output is registered already inverted so it cannot glitch on the invert bit path
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lvl_q <= '0;
      pwm_q <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (pwm_on[i] && ctl_q[i].en && free_q[i] == ilr_q[i]) begin
          lvl_q[i] <= 1'b1; // R16
          pwm_q[i] <= ~ctl_q[i].pwml;
        end else if (pwm_on[i] && ctl_q[i].en && free_q[i] == match_q[i]) begin
          lvl_q[i] <= 1'b0; // R16
          pwm_q[i] <= ctl_q[i].pwml;
        end else begin
          pwm_q[i] <= lvl_q[i] ^ ctl_q[i].pwml;
        end
      end
    end
  end

  // ****************************************
  // status flags and triggers
  // ****************************************
  // set beats clear; pwm never reaches these set terms
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cm_raw_q <= '0;
      ce_raw_q <= '0;
      adc_q    <= '0;
      dma_q    <= '0;
    end else if (ce_in) begin
      cm_raw_q <= hit | (cm_raw_q & ~cm_clr);    // R6 R15
      ce_raw_q <= ce_set | (ce_raw_q & ~ce_clr); // R11
      for (int i = 0; i < NUM_TIMERS; i++) begin
        adc_q[i] <= ctl_q[i].ote & (hit[i] | ce_set[i]); // R8
        dma_q[i] <= hit[i] | ce_set[i];                  // R18
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_chk
    sequence s_last_edge;
      ecnt_ev[g] && hit[g];
    endsequence
    property p_match_stop;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      s_last_edge |=> !ctl_q[g].en && cm_raw_q[g] && cnt_q[g] == {$past(pre_q[g]), $past(ilr_q[g])};
    endproperty
    a_match_stop: assert property (p_match_stop) else $error("edge-count match did not stop"); // R9
    property p_decrement;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      ecnt_ev[g] && !hit[g] |=> cnt_q[g] == $past(cnt_q[g]) - ONE_CNT;
    endproperty
    a_decrement: assert property (p_decrement) else $error("edge did not decrement"); // R5
    property p_raw_hold;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      cm_raw_q[g] && !cm_clr[g] |=> cm_raw_q[g];
    endproperty
    a_raw_hold: assert property (p_raw_hold) else $error("match flag lost"); // R6
    property p_enable_load;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      en_rise[g] |=> free_q[g] == $past(ilr_q[g]) && cnt_q[g][HW-1:0] == $past(ilr_q[g]);
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("enable did not load"); // R4
    property p_capture;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      ce_set[g] |=> cap_q[g] == $past(free_q[g]) && ce_raw_q[g] && dma_q[g];
    endproperty
    a_capture: assert property (p_capture) else $error("edge-time capture wrong"); // R11
    property p_timeout;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      ctl_q[g].en && !en_rise[g] && free_q[g] == ZERO_HALF |=> free_q[g] == $past(ilr_q[g]);
    endproperty
    a_timeout: assert property (p_timeout) else $error("no reload at timeout"); // R12
    property p_pwm_same;
      @(posedge sys_clk_in) disable iff (reset_in)
      pwm_on[g] |-> tread[g] == free_q[g] && !ce_set[g] && !hit[g];
    endproperty
    a_pwm_same: assert property (p_pwm_same) else $error("pwm count and value differ"); // R17
    property p_pwm_edges;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      pwm_on[g] && ctl_q[g].en && free_q[g] == ilr_q[g] |=> pwm_q[g] == ~$past(ctl_q[g].pwml);
    endproperty
    a_pwm_edges: assert property (p_pwm_edges) else $error("pwm not asserted at load"); // R16
    property p_adc;
      @(posedge sys_clk_in) disable iff (reset_in || !ce_in)
      (hit[g] || ce_set[g]) |=> adc_q[g] == $past(ctl_q[g].ote) && dma_q[g];
    endproperty
    a_adc: assert property (p_adc) else $error("trigger missing"); // R8
  end

endmodule : timer_capture_pwm

/* File: shared/timer_capture_pkg.sv */
// How it works
// R1 - capture source holds level two clocks minimum
// R2 - edge-count uses 24-bit prescale-plus-timer counter
// R3 - capture-mode clear selects edge-count; event field
// R4 - enabling loads count and value from load
// R5 - each selected edge decrements until match
// R6 - match sets sticky raw flag, masked view
// R7 - edge-count: count shows events, value free-runs
// R8 - capture event pulses adc trigger when enabled
// R9 - match reloads, clears enable, ignores edges
// R10 - capture-mode set: 16-bit edge-time counter
// R11 - edge-time edge copies count, sets event flag
// R12 - edge-time keeps running, reloads at timeout
// R13 - captured count held until next edge
// R14 - pwm selected by alt, capture, mode bits
// R15 - pwm counts to zero, reloads, no flags
// R16 - pwm sets at load, clears at match
// R17 - pwm count and value read identical
// R18 - each timer raises dma request on flag
// R19 - configs zero/one concatenate a and b halves
// R20 - 32-bit load write fills both halves
// R21 - 32-bit count/value read returns b:a
// R22 - pin synchronised, one pulse per edge
package timer_capture_pkg;

  // ****************************************
  // bus and geometry
  // ****************************************
  localparam int unsigned NUM_TIMERS = 2;
  localparam int unsigned AW         = 12;
  localparam int unsigned DW         = 32;
  localparam int unsigned HW         = 16;
  localparam int unsigned PW         = 8;
  localparam int unsigned CW         = HW + PW;
  localparam int unsigned LANE       = 8;

  // ****************************************
  // register offsets (timer b sits one stride above a; ctl, imr, ris, mis and icr hold b in the second byte lane of one word)
  // ****************************************
  localparam logic [AW-1:0] OFF_CFG      = 12'h000;
  localparam logic [AW-1:0] OFF_MODE     = 12'h004;
  localparam logic [AW-1:0] OFF_CTL      = 12'h00c;
  localparam logic [AW-1:0] OFF_IMR      = 12'h018;
  localparam logic [AW-1:0] OFF_RIS      = 12'h01c;
  localparam logic [AW-1:0] OFF_MIS      = 12'h020;
  localparam logic [AW-1:0] OFF_ICR      = 12'h024;
  localparam logic [AW-1:0] OFF_ILR      = 12'h028;
  localparam logic [AW-1:0] OFF_MATCH    = 12'h030;
  localparam logic [AW-1:0] OFF_PRE      = 12'h038;
  localparam logic [AW-1:0] OFF_PMATCH   = 12'h040;
  localparam logic [AW-1:0] OFF_COUNT    = 12'h048;
  localparam logic [AW-1:0] OFF_VALUE    = 12'h050;
  localparam logic [AW-1:0] TIMER_STRIDE = 12'h004;

  // ****************************************
  // fields and encodings
  // ****************************************
  localparam int unsigned RIS_CM_BIT  = 1;
  localparam int unsigned RIS_CE_BIT  = 2;
  localparam logic [2:0]  CFG_CAT32   = 3'h0;
  localparam logic [2:0]  CFG_CAT_RTC = 3'h1;
  localparam logic [2:0]  RST_CFG     = 3'h0;
  localparam logic [1:0]  MR_ONESHOT  = 2'h1;
  localparam logic [1:0]  MR_PERIODIC = 2'h2;
  localparam logic [1:0]  MR_CAPTURE  = 2'h3;
  localparam logic [1:0]  EVT_RISE    = 2'h0;
  localparam logic [1:0]  EVT_FALL    = 2'h1;
  localparam logic [1:0]  EVT_BOTH    = 2'h3;
  localparam logic [7:0]  CTL_RW_MASK = 8'h6d;
  localparam logic [15:0] RST_HALF    = 16'h0000;
  localparam logic [15:0] ZERO_HALF   = 16'h0000;
  localparam logic [15:0] ONE_HALF    = 16'h0001;
  localparam logic [23:0] ONE_CNT     = 24'h000001;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  typedef struct packed {
    logic       ams;
    logic       cmr;
    logic [1:0] mr;
  } mode_t;

  typedef struct packed {
    logic       rsv7;
    logic       pwml;
    logic       ote;
    logic       rsv4;
    logic [1:0] evt;
    logic       rsv1;
    logic       en;
  } ctl_t;

  localparam mode_t MODE_RST = 4'h0;
  localparam ctl_t  CTL_RST  = 8'h00;

endpackage : timer_capture_pkg

/* File: test/capture_source_model.sv */
`timescale 1ns/100ps
module capture_source_model (
  input  wire logic [timer_capture_pkg::NUM_TIMERS-1:0] dma_req_in,
  input  wire logic                                     sys_clk_in,
  output logic      [timer_capture_pkg::NUM_TIMERS-1:0] capture_pin_out
);
  import timer_capture_pkg::*;
  int dma_count [NUM_TIMERS];
  // ****************************************
  // capture pin source
  // ****************************************
  // pins idle low, nothing toggles before the bench asks
  initial begin
    capture_pin_out = '0;
  end
  // level held four clocks, twice the minimum, so the synchroniser never misses it
  task automatic toggle(input int idx);
    @(posedge sys_clk_in);
    capture_pin_out[idx] <= ~capture_pin_out[idx];
    repeat (4) @(posedge sys_clk_in);
  endtask : toggle
  // dma sink counts burst requests per channel
  always @(posedge sys_clk_in) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (dma_req_in[i] === 1'b1) begin
        dma_count[i] <= dma_count[i] + 1;
      end
    end
  end
endmodule : capture_source_model

/* File: test/timer_capture_pwm_tb.sv */
`timescale 1ns/100ps
module timer_capture_pwm_tb;
  import timer_capture_pkg::*;
  logic                  sys_clk_in = 1'b0;
  logic                  reset_in, ce_in, psel_in, penable_in, pwrite_in;
  logic [AW-1:0]         paddr_in;
  logic [DW-1:0]         pwdata_in, prdata_out, rd, cap;
  logic                  pready_out, pslverr_out;
  logic [NUM_TIMERS-1:0] capture_pin_in, pwm_out, adc_trig_out, dma_req_out;
  logic [32:0]           exp_q [$];
  logic [32:0]           msk_q [$];
  logic [31:0]           lfsr = 32'h0001658d;
  logic [1:0]            ev [4] = '{EVT_RISE, EVT_FALL, 2'h2, EVT_BOTH};
  int miscompares = 0;
  int total_checks = 0;
  int adc_count = 0;
  int n, d0, a0, hi;
  // ****************************************
  // clock, design and partner
  // ****************************************
  always #12.5 sys_clk_in = ~sys_clk_in;
  timer_capture_pwm timer_capture_pwm_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .capture_pin_in(capture_pin_in), .pwm_out(pwm_out), .adc_trig_out(adc_trig_out), .dma_req_out(dma_req_out));
  capture_source_model capture_source_model_inst (.dma_req_in(dma_req_out), .sys_clk_in(sys_clk_in),
    .capture_pin_out(capture_pin_in));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] msk = '1);
    total_checks++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // apb master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      summarize();
    end
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // read with a note of {slverr, data}; a zero mask only fetches the word
  task automatic rx(input logic [AW-1:0] a, input logic [31:0] e, input logic err = 1'b0, input logic m = 1'b1);
    exp_q.push_back({err, e});
    msk_q.push_back(m ? '1 : '0);
    apb(1'b0, a, 32'h0);
  endtask : rx
  // read results are compared when they appear, oldest note first
  always @(posedge sys_clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && exp_q.size() > 0) begin
      if (msk_q[0] != '0) begin
        check({pslverr_out, prdata_out}, exp_q[0], msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (adc_trig_out[0] === 1'b1) begin
      adc_count <= adc_count + 1;
    end
  end
  // a hang ends the run as a mismatch
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    miscompares++;
    summarize();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_in = 1'b1;
    ce_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = '0;
    pwdata_in = '0;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rx(12'hffc, 32'h0, 1'b1);
    wr(OFF_CFG, 32'h4);
    wr(OFF_MODE, 32'h3);
    wr(OFF_ILR, 32'ha);
    wr(OFF_MATCH, 32'h6);
    wr(OFF_PRE, 32'h0);
    wr(OFF_PMATCH, 32'h0);
    wr(OFF_IMR, 32'h2);
    // each event code over two full pin cycles; only both edges reach the match, code two counts nothing
    for (int i = 0; i < 4; i++) begin
      n = (ev[i] == EVT_BOTH) ? 4 : ((ev[i] == 2'h2) ? 0 : 2);
      d0 = capture_source_model_inst.dma_count[0];
      a0 = adc_count;
      wr(OFF_CTL, {26'h0, 1'b1, 1'b0, ev[i], 1'b0, 1'b1});
      repeat (4) capture_source_model_inst.toggle(0);
      repeat (4) @(posedge sys_clk_in);
      rx(OFF_COUNT, (n == 4) ? 32'ha : 32'ha - n);
      rx(OFF_RIS, (n == 4) ? 32'h2 : 32'h0);
      rx(OFF_MIS, (n == 4) ? 32'h2 : 32'h0);
      rx(OFF_CTL, {26'h0, 1'b1, 1'b0, ev[i], 1'b0, n != 4});
      check(33'(capture_source_model_inst.dma_count[0] - d0), (n == 4) ? 33'h1 : 33'h0);
      // in edge-count the trigger follows the match, not every counted edge
      check(33'(adc_count - a0), (n == 4) ? 33'h1 : 33'h0);
      if (n != 4) begin
        wr(OFF_CTL, 32'h0);
      end
    end
    // stopped after the match: later edges change nothing
    a0 = adc_count;
    repeat (2) capture_source_model_inst.toggle(0);
    rx(OFF_COUNT, 32'ha);
    check(33'(adc_count - a0), 33'h0);
    wr(OFF_ICR, 32'h2);
    rx(OFF_RIS, 32'h0);
    // edge-time: one rising capture, then the count must stand still
    wr(OFF_MODE, 32'h7);
    wr(OFF_ILR, 32'hffff);
    d0 = capture_source_model_inst.dma_count[0];
    a0 = adc_count;
    wr(OFF_CTL, 32'h21);
    repeat (2) capture_source_model_inst.toggle(0);
    rx(OFF_RIS, 32'h4);
    rx(OFF_COUNT, 32'h0, 1'b0, 1'b0);
    cap = rd;
    check(33'(cap < 32'hffff), 33'h1);
    repeat (10) @(posedge sys_clk_in);
    rx(OFF_COUNT, cap);
    rx(OFF_VALUE, 32'h0, 1'b0, 1'b0);
    check(33'(rd < cap), 33'h1);
    // a low clock enable freezes the free counter: four enabled edges lie between the two latches
    n = int'(rd[15:0]);
    ce_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    ce_in <= 1'b1;
    rx(OFF_VALUE, 32'h0, 1'b0, 1'b0);
    check(33'(n - int'(rd[15:0])), 33'h4);
    check(33'(capture_source_model_inst.dma_count[0] - d0), 33'h1);
    check(33'(adc_count - a0), 33'h1);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h6);
    // pwm: period ten, high from load down to match, then inverted
    wr(OFF_ILR, 32'h9);
    wr(OFF_MATCH, 32'h3);
    // periodic code plain, one-shot code inverted; both select pwm
    for (int v = 0; v < 2; v++) begin
      wr(OFF_MODE, (v == 1) ? 32'h9 : 32'ha);
      wr(OFF_CTL, (v == 1) ? 32'h41 : 32'h01);
      repeat (12) @(posedge sys_clk_in);
      hi = 0;
      repeat (10) begin
        @(posedge sys_clk_in);
        hi += int'(pwm_out[0] === 1'b1);
      end
      check(33'(hi), (v == 1) ? 33'h4 : 33'h6);
      wr(OFF_CTL, 32'h0);
    end
    rx(OFF_RIS, 32'h0);
    // concatenated load write fills timer b from the upper half; a value read returns b above a
    rx(OFF_VALUE, 32'h0, 1'b0, 1'b0);
    d0 = int'(rd[15:0]);
    wr(OFF_CFG, 32'h0);
    cap = next_rand();
    wr(OFF_ILR, cap);
    rx(OFF_ILR + TIMER_STRIDE, {16'h0, cap[31:16]});
    rx(OFF_ILR, cap);
    wr(OFF_CTL, 32'h100);
    wr(OFF_CTL, 32'h0);
    rx(OFF_VALUE + TIMER_STRIDE, 32'h0, 1'b0, 1'b0);
    rx(OFF_VALUE, {rd[15:0], d0[15:0]});
    summarize();
  end
endmodule : timer_capture_pwm_tb
